/* rtl/jrx_core.sv */
// receiver port block: register slave, lane capture and sample stream out
//
// How it works
// - phase refs time the link-to-frame handoff
// - link and transport logic reset by main reset
// - phy stage has its own async reset
// - register port has own clock and reset
// - unselected register accesses are ignored
// - address is byte offset, words four apart
// - 32-bit write and read data words
// - stall held low, read data same cycle
// - sample word width is M*S*mult*N
// - octets big-endian, first octet on top
// - lane 0 in the most significant slice
// - control bits width is M*S*mult*CS
// - no backpressure, valid marks usable cycles
`default_nettype none

module jrx_core #(
    parameter int unsigned LANES      = 1,
    parameter int unsigned CONV_M     = 1,
    parameter int unsigned SAMP_S     = 1,
    parameter int unsigned RES_N      = 16,
    parameter int unsigned WIDTH_MULT = 8,
    parameter int unsigned CTRL_CS    = 1
) (
    input  wire logic                    rx_lane_word_clock_i,
    input  wire logic                    lane_word_clock_phase_ref_i,
    input  wire logic                    rx_sample_frame_clock_i,
    input  wire logic                    frame_clock_phase_ref_i,
    input  wire logic                    reg_port_clock_i,
    input  wire logic                    link_transport_reset_low_n_i,
    input  wire logic                    phy_reset_low_n_i,
    input  wire logic                    reg_port_reset_low_n_i,
    input  wire jrx_pkg::jrx_reg_req_type reg_port_req_i,
    output logic [jrx_pkg::WORD_W-1:0]  reg_port_rd_word_o,
    output logic                         reg_port_stall_o,
    input  wire logic [CONV_M*SAMP_S*WIDTH_MULT*RES_N-1:0] lane_word_i,
    input  wire logic [CONV_M*SAMP_S*WIDTH_MULT*CTRL_CS-1:0] lane_ctrl_i,
    input  wire logic                    lane_word_valid_i,
    output logic [CONV_M*SAMP_S*WIDTH_MULT*RES_N-1:0] sample_stream_word_o,
    output logic [CONV_M*SAMP_S*WIDTH_MULT*CTRL_CS-1:0] sample_ctrl_bits_out_o,
    output logic                         sample_stream_valid_o,
    input  wire logic                    sample_stream_accept_i
);
    import jrx_pkg::*;

    // ========================================================================
    // widths
    // ========================================================================
    localparam int unsigned DW = CONV_M*SAMP_S*WIDTH_MULT*RES_N;
    localparam int unsigned CW = CONV_M*SAMP_S*WIDTH_MULT*CTRL_CS;
    localparam int unsigned LW = DW / LANES;
    localparam int unsigned OCTETS = LW / OCTET_W;

    // lanes arrive with lane 0 in the low slice and first octet in its low
    // byte; the stream wants lane 0 and its first octet at the top
    function automatic logic [DW-1:0] to_big_endian(input logic [DW-1:0] d);
        logic [DW-1:0] o;
        o = '0;
        for (int k = 0; k < LANES; k++) begin
            for (int j = 0; j < OCTETS; j++) begin
                o[DW-1-k*LW-j*OCTET_W -: OCTET_W] =
                    d[k*LW+j*OCTET_W +: OCTET_W];
            end
        end
        return o;
    endfunction

    // ========================================================================
    // phy stage state (phy reset)
    // ========================================================================
    typedef struct packed {
        logic [DW-1:0] data;
        logic [CW-1:0] ctrl;
        logic          vld;
    } jrx_phy_state_type;

    jrx_phy_state_type phy_r;
    jrx_phy_state_type phy_nxt;
    always_comb begin
        phy_nxt      = phy_r;
        phy_nxt.data = lane_word_i;
        phy_nxt.ctrl = lane_ctrl_i;
        phy_nxt.vld  = lane_word_valid_i;
    end

    always_ff @(posedge rx_lane_word_clock_i or negedge phy_reset_low_n_i) begin
        if (!phy_reset_low_n_i) begin
            phy_r <= '0;
        end else begin
            phy_r <= phy_nxt;
        end
    end

    // ========================================================================
    // link stage state (main reset)
    // ========================================================================
    typedef struct packed {
        logic          ph_s1;
        logic          ph_s2;
        logic [DW-1:0] data;
        logic [CW-1:0] ctrl;
        logic          vld;
    } jrx_link_state_type;

    jrx_link_state_type lnk_r;
    jrx_link_state_type lnk_nxt;
    // capture only in the link cycle the phase reference marks, so the
    // holding register is quiet when the frame side samples it
    always_comb begin
        lnk_nxt       = lnk_r;
        lnk_nxt.ph_s1 = lane_word_clock_phase_ref_i;
        lnk_nxt.ph_s2 = lnk_r.ph_s1;
        if (lnk_r.ph_s2) begin
            lnk_nxt.data = to_big_endian(phy_r.data);
            lnk_nxt.ctrl = phy_r.ctrl;
            lnk_nxt.vld  = phy_r.vld;
        end
    end

    always_ff @(posedge rx_lane_word_clock_i
                or negedge link_transport_reset_low_n_i) begin
        if (!link_transport_reset_low_n_i) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // ========================================================================
    // frame / transport state (main reset)
    // ========================================================================
    typedef struct packed {
        logic          ph_s1;
        logic          ph_s2;
        logic          ph_d;
        logic          en_s1;
        logic          en_s2;
        logic [DW-1:0] data;
        logic [CW-1:0] ctrl;
        logic          valid;
        logic          seen;
    } jrx_frm_state_type;

    jrx_frm_state_type frm_r;
    jrx_frm_state_type frm_nxt;
    logic              frm_load;
    logic              ctrl_en;
    assign frm_load = frm_r.ph_s2 && !frm_r.ph_d;
    // valid only when the sink is accepting: there is no way to hold data
    always_comb begin
        frm_nxt       = frm_r;
        frm_nxt.ph_s1 = frame_clock_phase_ref_i;
        frm_nxt.ph_s2 = frm_r.ph_s1;
        frm_nxt.ph_d  = frm_r.ph_s2;
        frm_nxt.en_s1 = ctrl_en;
        frm_nxt.en_s2 = frm_r.en_s1;
        frm_nxt.valid = 1'b0;
        if (frm_load) begin
            frm_nxt.data  = lnk_r.data;
            frm_nxt.ctrl  = lnk_r.ctrl;
            frm_nxt.valid = lnk_r.vld && frm_r.en_s2
                            && sample_stream_accept_i;
        end
        frm_nxt.seen = frm_nxt.valid;
    end

    always_ff @(posedge rx_sample_frame_clock_i
                or negedge link_transport_reset_low_n_i) begin
        if (!link_transport_reset_low_n_i) begin
            frm_r <= '0;
        end else begin
            frm_r <= frm_nxt;
        end
    end

    assign sample_stream_word_o   = frm_r.data;
    assign sample_ctrl_bits_out_o = frm_r.ctrl;
    assign sample_stream_valid_o  = frm_r.valid;

    // ========================================================================
    // register port state (own clock and reset)
    // ========================================================================
    typedef struct packed {
        logic              en;
        logic [WORD_W-1:0] scratch;
        logic              seen_s1;
        logic              seen_s2;
        logic              sticky;
        logic              stall;
    } jrx_reg_state_type;

    jrx_reg_state_type reg_r;
    jrx_reg_state_type reg_nxt;
    logic              acc_wr;
    logic              acc_rd;
    // nothing is decoded unless the port is selected
    assign acc_wr  = reg_port_req_i.sel && reg_port_req_i.wr;
    assign acc_rd  = reg_port_req_i.sel && reg_port_req_i.rd;
    assign ctrl_en = reg_r.en;
    always_comb begin
        reg_nxt         = reg_r;
        reg_nxt.seen_s1 = frm_r.seen;
        reg_nxt.seen_s2 = reg_r.seen_s1;
        reg_nxt.stall   = 1'b0;
        // writing one clears the flag, but a new sighting wins
        if (acc_wr && reg_port_req_i.addr == OFS_STATUS
            && reg_port_req_i.wdata[STAT_SEEN_BIT]) begin
            reg_nxt.sticky = 1'b0;
        end
        if (reg_r.seen_s2) begin
            reg_nxt.sticky = 1'b1;
        end
        if (acc_wr) begin
            case (reg_port_req_i.addr)
                OFS_CTRL: begin
                    reg_nxt.en = reg_port_req_i.wdata[CTRL_EN_BIT];
                end
                OFS_SCRATCH: begin
                    reg_nxt.scratch = reg_port_req_i.wdata;
                end
                default: reg_nxt.en = reg_r.en;
            endcase
        end
    end

    always_ff @(posedge reg_port_clock_i or negedge reg_port_reset_low_n_i) begin
        if (!reg_port_reset_low_n_i) begin
            reg_r         <= '0;
            reg_r.en      <= CTRL_EN_RST;
            reg_r.scratch <= SCRATCH_RST;
        end else begin
            reg_r <= reg_nxt;
        end
    end

    // read data follows the selected word in the access cycle itself, so
    // the master never waits; it is a mux of flops only
    always_comb begin
        reg_port_rd_word_o = UNMAPPED_RD;
        if (acc_rd) begin
            case (reg_port_req_i.addr)
                OFS_CTRL: begin
                    reg_port_rd_word_o[CTRL_EN_BIT] = reg_r.en;
                end
                OFS_STATUS: begin
                    reg_port_rd_word_o[STAT_SEEN_BIT] = reg_r.sticky;
                    reg_port_rd_word_o[STAT_LIVE_BIT] = reg_r.seen_s2;
                end
                OFS_SCRATCH: begin
                    reg_port_rd_word_o = reg_r.scratch;
                end
                default: reg_port_rd_word_o = UNMAPPED_RD;
            endcase
        end
    end

    assign reg_port_stall_o = reg_r.stall;

    // ========================================================================
    // checks
    // ========================================================================
    chk_stall_low: assert property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        !reg_port_stall_o)
        else $error("stall output left low level");
    chk_unsel_ignored: assert property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        !reg_port_req_i.sel |=> $stable(reg_r.scratch) && $stable(reg_r.en))
        else $error("unselected access changed a register");
    chk_write_lands: assert property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        acc_wr && reg_port_req_i.addr == OFS_SCRATCH
        |=> reg_r.scratch == $past(reg_port_req_i.wdata))
        else $error("scratch write not taken on next edge");
    chk_read_same: assert property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        acc_rd && reg_port_req_i.addr == OFS_SCRATCH
        |-> reg_port_rd_word_o == reg_r.scratch)
        else $error("read data not returned in access cycle");
    chk_sticky_hold: assert property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        reg_r.seen_s2 |=> reg_r.sticky)
        else $error("seen flag lost against clear");
    chk_octet_order: assert property (
        @(posedge rx_lane_word_clock_i)
        disable iff (!link_transport_reset_low_n_i || !phy_reset_low_n_i)
        lnk_r.ph_s2 |=> lnk_r.data[DW-1 -: OCTET_W] == $past(phy_r.data[7:0]))
        else $error("first octet of lane 0 not at top");
    chk_valid_cause: assert property (
        @(posedge rx_sample_frame_clock_i)
        disable iff (!link_transport_reset_low_n_i)
        frm_load && lnk_r.vld && frm_r.en_s2 && sample_stream_accept_i
        |=> sample_stream_valid_o)
        else $error("accepted frame not marked valid");
    chk_valid_accept: assert property (
        @(posedge rx_sample_frame_clock_i)
        disable iff (!link_transport_reset_low_n_i)
        sample_stream_valid_o |-> $past(sample_stream_accept_i)
        && $past(frm_load))
        else $error("valid without accept or load");
    chk_word_hold: assert property (
        @(posedge rx_sample_frame_clock_i)
        disable iff (!link_transport_reset_low_n_i)
        !frm_load |=> $stable(sample_stream_word_o)
        && $stable(sample_ctrl_bits_out_o))
        else $error("stream word moved outside a load");
    chk_reset_invalid: assert property (
        @(posedge rx_sample_frame_clock_i)
        !link_transport_reset_low_n_i |-> !sample_stream_valid_o)
        else $error("valid seen during link reset");
    cov_reg_write: cover property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        acc_wr ##1 acc_rd);
    cov_stream_valid: cover property (
        @(posedge rx_sample_frame_clock_i)
        disable iff (!link_transport_reset_low_n_i)
        sample_stream_valid_o);
    cov_drop: cover property (
        @(posedge rx_sample_frame_clock_i)
        disable iff (!link_transport_reset_low_n_i)
        frm_load && lnk_r.vld && !sample_stream_accept_i);
    cov_sticky: cover property (
        @(posedge reg_port_clock_i) disable iff (!reg_port_reset_low_n_i)
        reg_r.sticky);

endmodule : jrx_core

`default_nettype wire

/* rtl/jrx_pkg.sv */
// shared constants and carrier types for the receiver port block
`default_nettype none

package jrx_pkg;

    // ========================================================================
    // register port geometry
    // ========================================================================
    localparam int unsigned ADDR_W      = 10;
    localparam int unsigned WORD_W      = 32;
    localparam int unsigned OCTET_W     = 8;

    // byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 10'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 10'h004;
    localparam logic [ADDR_W-1:0] OFS_SCRATCH = 10'h008;

    // field positions
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned STAT_SEEN_BIT   = 0;
    localparam int unsigned STAT_LIVE_BIT   = 1;

    // values after reset, and read value of unmapped addresses
    localparam logic        CTRL_EN_RST     = 1'h0;
    localparam logic [WORD_W-1:0] SCRATCH_RST = 32'h0000_0000;
    localparam logic [WORD_W-1:0] UNMAPPED_RD = 32'h0000_0000;

    // ========================================================================
    // carrier for one register port request
    // ========================================================================
    typedef struct packed {
        logic              sel;
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } jrx_reg_req_type;

endpackage : jrx_pkg

`default_nettype wire

/* sim/jrx_sink_model.sv */
// application-side sink model for the receiver sample stream
`default_nettype none

module jrx_sink_model (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        hold_off_i,
    input  wire logic        valid_i,
    output logic             accept_o,
    output logic [7:0]       beats_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // ready level and beat counting
    // ========================================================================
    // ready is a plain level; the stream cannot be held back, so a beat
    // offered while ready is high is taken in that very cycle
    assign accept_o = ~hold_off_i;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            beats_o <= 8'h00;
        end else if (valid_i && accept_o) begin
            beats_o <= beats_o + 8'h01;
        end
    end
endmodule // jrx_sink_model

`default_nettype wire

/* sim/jrx_core_tb.sv */
// self-checking bench for the receiver port block
`default_nettype none

module jrx_core_tb;
    import jrx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // clocks, resets and stimulus
    // ========================================================================
    logic               fclk, lclk, rclk;
    logic               lref, fref;
    logic               link_rst_n, phy_rst_n, reg_rst_n;
    jrx_reg_req_type    req;
    logic [WORD_W-1:0]  rd_word;
    logic               stall;
    logic [127:0]       lane_word, s_word;
    logic [7:0]         lane_ctrl, s_ctrl, beats;
    logic               lane_vld, s_valid, accept, hold_off;
    int                 err_count, samples_checked;

    // link clock is half the frame clock, both from one source
    initial begin
        fclk = 1'b0;
        lclk = 1'b0;
        forever begin
            #5 fclk = ~fclk;
            if (fclk) lclk = ~lclk;
        end
    end

    // register clock runs on its own, off phase from the stream clocks
    initial begin
        rclk = 1'b0;
        #2;
        forever #5 rclk = ~rclk;
    end

    jrx_core #(.LANES(2)) dut (
        .rx_lane_word_clock_i         (lclk),
        .lane_word_clock_phase_ref_i  (lref),
        .rx_sample_frame_clock_i      (fclk),
        .frame_clock_phase_ref_i      (fref),
        .reg_port_clock_i             (rclk),
        .link_transport_reset_low_n_i (link_rst_n),
        .phy_reset_low_n_i            (phy_rst_n),
        .reg_port_reset_low_n_i       (reg_rst_n),
        .reg_port_req_i               (req),
        .reg_port_rd_word_o           (rd_word),
        .reg_port_stall_o             (stall),
        .lane_word_i                  (lane_word),
        .lane_ctrl_i                  (lane_ctrl),
        .lane_word_valid_i            (lane_vld),
        .sample_stream_word_o         (s_word),
        .sample_ctrl_bits_out_o       (s_ctrl),
        .sample_stream_valid_o        (s_valid),
        .sample_stream_accept_i       (accept)
    );

    jrx_sink_model sink (
        .clk_i      (fclk),
        .reset_n_i  (link_rst_n),
        .hold_off_i (hold_off),
        .valid_i    (s_valid),
        .accept_o   (accept),
        .beats_o    (beats)
    );

    // ========================================================================
    // shared tasks
    // ========================================================================
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one access; read data is taken mid-cycle while the request stands
    task automatic reg_op(input logic sel, input logic wr,
                          input logic [ADDR_W-1:0] a,
                          input logic [WORD_W-1:0] d,
                          output logic [WORD_W-1:0] q);
        @(posedge rclk);
        req <= '{sel: sel, rd: ~wr, wr: wr, addr: a, wdata: d};
        @(negedge rclk);
        q = rd_word;
        check({127'h0, stall}, 128'h0);
        @(posedge rclk);
        req <= '0;
    endtask

    // one load: first octet of each lane in its low byte at the input
    task automatic stream_load(input logic [7:0] seed, input logic acc);
        logic [127:0] w, exp;
        logic [7:0]   b0;
        int           seen;
        seen = 0;
        b0 = beats;
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 8; j++) begin
                w[k*64+j*8 +: 8] = seed + 8'(k*8+j);
                exp[127-k*64-j*8 -: 8] = seed + 8'(k*8+j);
            end
        end
        @(posedge lclk);
        lane_word <= w;
        lane_ctrl <= ~seed;
        lane_vld  <= 1'b1;
        repeat (4) @(posedge lclk);
        @(posedge fclk);
        hold_off <= ~acc;
        fref     <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(negedge fclk);
            if (s_valid === 1'b1) seen++;
        end
        @(posedge fclk);
        fref <= 1'b0;
        check(128'(seen), acc ? 128'h1 : 128'h0);
        check(128'(beats - b0), acc ? 128'h1 : 128'h0);
        check(s_word, exp);
        check({120'h0, s_ctrl}, {120'h0, ~seed});
    endtask

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic reset_phase();
        repeat (16) @(posedge rclk);
        check({126'h0, s_valid, stall}, 128'h0);
        check(s_word, 128'h0);
        check({96'h0, rd_word}, 128'h0);
        @(posedge rclk);
        link_rst_n <= 1'b1;
        phy_rst_n  <= 1'b1;
        reg_rst_n  <= 1'b1;
    endtask

    task automatic reg_scenario();
        logic [WORD_W-1:0] q;
        reg_op(1'b1, 1'b0, OFS_SCRATCH, 32'h0, q);
        check({96'h0, q}, {96'h0, SCRATCH_RST});
        reg_op(1'b1, 1'b1, OFS_SCRATCH, 32'hA5C3_0F96, q);
        reg_op(1'b1, 1'b0, OFS_SCRATCH, 32'h0, q);
        check({96'h0, q}, 128'hA5C3_0F96);
        reg_op(1'b0, 1'b1, OFS_SCRATCH, 32'h1234_5678, q);
        reg_op(1'b1, 1'b0, OFS_SCRATCH, 32'h0, q);
        check({96'h0, q}, 128'hA5C3_0F96);
        reg_op(1'b1, 1'b1, 10'h00C, 32'hFFFF_FFFF, q);
        reg_op(1'b1, 1'b0, 10'h00C, 32'h0, q);
        check({96'h0, q}, {96'h0, UNMAPPED_RD});
        reg_op(1'b1, 1'b1, OFS_CTRL, 32'h0000_0001, q);
        reg_op(1'b1, 1'b0, OFS_CTRL, 32'h0, q);
        check({127'h0, q[CTRL_EN_BIT]}, 128'h1);
    endtask

    task automatic reset_scenario();
        logic [127:0]      held;
        logic [WORD_W-1:0] q;
        held = s_word;
        @(posedge lclk);
        phy_rst_n <= 1'b0;
        repeat (3) @(posedge fclk);
        check(s_word, held);
        @(posedge lclk);
        phy_rst_n <= 1'b1;
        @(posedge fclk);
        link_rst_n <= 1'b0;
        @(negedge fclk);
        check({127'h0, s_valid}, 128'h0);
        check(s_word, 128'h0);
        reg_op(1'b1, 1'b0, OFS_SCRATCH, 32'h0, q);
        check({96'h0, q}, 128'hA5C3_0F96);
        @(posedge fclk);
        link_rst_n <= 1'b1;
    endtask

    task automatic status_scenario();
        logic [WORD_W-1:0] q;
        reg_op(1'b1, 1'b0, OFS_STATUS, 32'h0, q);
        check({127'h0, q[STAT_SEEN_BIT]}, 128'h1);
        reg_op(1'b1, 1'b1, OFS_STATUS, 32'h0000_0001, q);
        reg_op(1'b1, 1'b0, OFS_STATUS, 32'h0, q);
        check({96'h0, q}, 128'h0);
    endtask

    // with the link phase reference low the hold must not take new words
    task automatic gate_scenario();
        logic [127:0] held;
        held = s_word;
        @(posedge lclk);
        lref <= 1'b0;
        repeat (3) @(posedge lclk);
        lane_word <= ~lane_word;
        repeat (4) @(posedge lclk);
        @(posedge fclk);
        fref <= 1'b1;
        repeat (6) @(posedge fclk);
        fref <= 1'b0;
        @(negedge fclk);
        check(s_word, held);
        @(posedge lclk);
        lref <= 1'b1;
    endtask

    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        err_count       = 0;
        samples_checked = 0;
        link_rst_n = 1'b0;
        phy_rst_n  = 1'b0;
        reg_rst_n  = 1'b0;
        lref       = 1'b1;
        fref       = 1'b0;
        req        = '0;
        lane_word  = 128'h0;
        lane_ctrl  = 8'h00;
        lane_vld   = 1'b0;
        hold_off   = 1'b0;
        reset_phase();
        reg_scenario();
        stream_load(8'h10, 1'b1);
        stream_load(8'h80, 1'b1);
        stream_load(8'hE0, 1'b0);
        status_scenario();
        reset_scenario();
        stream_load(8'h40, 1'b1);
        gate_scenario();
        conclude();
    end
endmodule // jrx_core_tb

`default_nettype wire
